// ===== mds_pkg.sv
`default_nettype none
package mds_pkg;

  // register offsets, six-bit serial address space
  localparam logic [5:0] OFS_DEVICE_STATUS_ONE    = 6'h00;
  localparam logic [5:0] OFS_THERMAL_STATUS       = 6'h04;
  localparam logic [5:0] OFS_SUPPLY_STATUS        = 6'h05;
  localparam logic [5:0] OFS_DRIVER_STATUS        = 6'h06;
  localparam logic [5:0] OFS_SYSTEM_STATUS        = 6'h07;
  localparam logic [5:0] OFS_SYNC_PERIOD          = 6'h0c;
  localparam logic [5:0] OFS_FAULT_MODE           = 6'h10;
  localparam logic [5:0] OFS_SYSTEM_FAULT_CONTROL = 6'h12;
  localparam logic [5:0] OFS_DRIVER_FAULT_CONTROL = 6'h13;
  localparam logic [5:0] OFS_FAULT_TIMING_CONTROL = 6'h16;
  localparam logic [5:0] OFS_FAULT_CLEAR          = 6'h17;
  localparam logic [5:0] OFS_GENERATOR_PERIOD     = 6'h18;
  localparam logic [5:0] OFS_PHASE_A_DUTY         = 6'h19;
  localparam logic [5:0] OFS_PHASE_B_DUTY         = 6'h1a;
  localparam logic [5:0] OFS_PHASE_C_DUTY         = 6'h1b;
  localparam logic [5:0] OFS_OUTPUT_STATE         = 6'h1c;
  localparam logic [5:0] OFS_GENERATOR_CONTROL    = 6'h1d;
  localparam logic [5:0] OFS_MODULATION_CONTROL   = 6'h20;
  localparam logic [5:0] OFS_PREDRIVER_CONTROL    = 6'h22;
  localparam logic [5:0] OFS_SENSE_AMP_CONTROL    = 6'h23;
  localparam logic [5:0] OFS_SYSTEM_CONTROL       = 6'h3f;

  // storage slots of the read/write registers
  localparam int          NUM_RW     = 15;
  localparam logic [3:0]  IDX_SYSCTL = 4'he;
  localparam logic [15:0] RW_RESET   = 16'h0000;
  localparam logic [15:0] STS_RESET  = 16'h0000;

  // field positions
  localparam int BIT_PARITY_ENABLE = 0;   // in system_control
  localparam int BIT_CLEAR_ALL     = 0;   // in fault_clear
  localparam int BIT_HDR_READ      = 7;   // header: 1 = read
  localparam int DS1_PARITY        = 15;
  localparam int DS1_OTP           = 8;
  localparam int DS1_RESET         = 7;
  localparam int DS1_COMM          = 6;
  localparam int DS1_OCP           = 5;
  localparam int DS1_UV            = 2;
  localparam int DS1_OT            = 1;
  localparam int DS1_FAULT         = 0;

  // latched event vector layout
  localparam int EV_W         = 10;
  localparam int EV_OT_WARN   = 0;
  localparam int EV_OT_SHDN   = 1;
  localparam int EV_CP_UV     = 2;
  localparam int EV_ANALOG_SUPPLY_UV   = 3;
  localparam int EV_VIN_UV    = 4;
  localparam int EV_OCP       = 5;
  localparam int EV_OTP       = 6;
  localparam int EV_POR       = 7;
  localparam int EV_PARITY    = 8;
  localparam int EV_FRAME     = 9;
  localparam logic [9:0] EV_RESET = 10'h080;

  // last serial clock count of the header and of each data word
  localparam logic [3:0] HDR_LAST  = 4'h7;
  localparam logic [3:0] WORD_LAST = 4'hf;

  typedef enum logic [2:0] {
    SPI_IDLE   = 3'b001,
    SPI_HEADER = 3'b010,
    SPI_DATA   = 3'b100
  } mds_spi_t;

endpackage
`default_nettype wire

// ===== mds_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module mds_sticky #(
  parameter int         W   = 10,
  parameter logic [9:0] RST = 10'h000
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flag_o
);

  typedef struct packed {
    logic [W-1:0] flag;
  } mds_sticky_t;

  mds_sticky_t s_q;
  mds_sticky_t s_d;

  // set beats clear so an event in the clearing cycle survives
  always_comb begin
    s_d      = s_q;
    s_d.flag = (s_q.flag & ~clr_i) | set_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q.flag <= RST[W-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_o = s_q.flag;

endmodule
`default_nettype wire

// ===== mds_regmap.sv
//Function
// - status registers at 0h, 4h-7h
// - sync, fault mode/control registers placed
// - fault clear decoded at 17h
// - generator period 18h, duties 19h-1Bh
// - state, control, predriver, amp registers placed
// - system control decoded at 3Fh
// - thermal status resets to zero
// - bit 15 returns parity when enabled
// - bit 8 reports OTP read fault
// - bit 7 power-on flag, reset 0080h
// - bit 6 reports communication fault
// - bit 5 reports overcurrent
// - bit 2 reports any supply undervoltage
// - bit 1 reports overtemperature warning/shutdown
// - parity checking disabled after reset
// - parity error latched, pinned, and reported
`timescale 1ns/1ps
`default_nettype none
module mds_regmap
  import mds_pkg::*;
(
  input  wire logic REF_CLK_I,
  input  wire logic RESET_N_I,
  input  wire logic SCLK_I,
  input  wire logic SCS_N_I,
  input  wire logic SDI_I,
  output logic      SDO_O,
  output logic      SDO_OE_N_O,
  input  wire logic OT_WARN_I,
  input  wire logic OT_SHDN_I,
  input  wire logic CP_UV_I,
  input  wire logic ANALOG_SUPPLY_UV_I,
  input  wire logic VIN_UV_I,
  input  wire logic OCP_I,
  input  wire logic OTP_FAULT_I,
  output logic      FAULT_N_O,
  output logic      PARITY_ENABLE_O
);
  import mds_pkg::*;

  typedef struct packed {
    mds_spi_t                 state;
    logic                     sclk;
    logic                     cs_n;
    logic [3:0]               cnt;
    logic [15:0]              in_sh;
    logic [15:0]              out_sh;
    logic                     sdo;
    logic                     oe_n;
    logic                     rd;
    logic                     blk;
    logic [5:0]               rptr;
    logic [5:0]               wptr;
    logic [NUM_RW-1:0][15:0]  regs;
    logic                     par_ev;
    logic                     frm_ev;
    logic                     clr;
    logic                     fault_n;
  } mds_reg_t;

  mds_reg_t        r_q;
  mds_reg_t        r_d;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  // map an offset to its storage slot; valid low for status or holes
  function automatic logic [4:0] slot_of(input logic [5:0] a);
    logic [4:0] s;
    s = 5'h10;
    if (a == OFS_SYNC_PERIOD) begin
      s = 5'h00;
    end else if (a == OFS_FAULT_MODE) begin
      s = 5'h01;
    end else if (a == OFS_SYSTEM_FAULT_CONTROL) begin
      s = 5'h02;
    end else if (a == OFS_DRIVER_FAULT_CONTROL) begin
      s = 5'h03;
    end else if (a == OFS_FAULT_TIMING_CONTROL) begin
      s = 5'h04;
    end else if (a == OFS_GENERATOR_PERIOD) begin
      s = 5'h05;
    end else if (a == OFS_PHASE_A_DUTY) begin
      s = 5'h06;
    end else if (a == OFS_PHASE_B_DUTY) begin
      s = 5'h07;
    end else if (a == OFS_PHASE_C_DUTY) begin
      s = 5'h08;
    end else if (a == OFS_OUTPUT_STATE) begin
      s = 5'h09;
    end else if (a == OFS_GENERATOR_CONTROL) begin
      s = 5'h0a;
    end else if (a == OFS_MODULATION_CONTROL) begin
      s = 5'h0b;
    end else if (a == OFS_PREDRIVER_CONTROL) begin
      s = 5'h0c;
    end else if (a == OFS_SENSE_AMP_CONTROL) begin
      s = 5'h0d;
    end else if (a == OFS_SYSTEM_CONTROL) begin
      s = {1'b0, IDX_SYSCTL};
    end
    return s;
  endfunction

  // even parity over the low fifteen bits lands in bit 15
  function automatic logic [15:0] with_parity(input logic [15:0] v,
                                              input logic        pen);
    logic [15:0] o;
    o = v;
    if (pen) begin
      o[15] = ^v[14:0];
    end
    return o;
  endfunction

  logic        pen;
  logic [15:0] ds1;
  logic [15:0] system_status;
  logic [15:0] therm_sts;
  logic [15:0] supply_status;
  logic [15:0] driver_status;

  assign pen = r_q.regs[IDX_SYSCTL][BIT_PARITY_ENABLE];

  // device status one, reserved bits stay zero
  always_comb begin
    ds1            = STS_RESET;
    ds1[DS1_OTP]   = ev[EV_OTP];
    ds1[DS1_RESET] = ev[EV_POR];
    ds1[DS1_COMM]  = ev[EV_PARITY] | ev[EV_FRAME];
    ds1[DS1_OCP]   = ev[EV_OCP];
    ds1[DS1_UV]    = |ev[EV_VIN_UV:EV_CP_UV];
    ds1[DS1_OT]    = ev[EV_OT_WARN] | ev[EV_OT_SHDN];
    ds1[DS1_FAULT] = |{ev[EV_FRAME:EV_PARITY], ev[EV_OTP:EV_OT_WARN]};
    ds1            = with_parity(ds1, pen);
  end

  // detail status words, all zero from reset
  always_comb begin
    therm_sts                 = STS_RESET;
    therm_sts[1:0]            = ev[EV_OT_SHDN:EV_OT_WARN];
    supply_status                   = STS_RESET;
    supply_status[2:0]              = ev[EV_VIN_UV:EV_CP_UV];
    driver_status                   = STS_RESET;
    driver_status[0]                = ev[EV_OCP];
    system_status                   = STS_RESET;
    system_status[1:0]              = ev[EV_FRAME:EV_PARITY];
  end

  // read mux; holes read zero
  function automatic logic [15:0] read_of(input logic [5:0]               a,
                                          input logic [NUM_RW-1:0][15:0] rg,
                                          input logic [15:0]              d1,
                                          input logic [15:0]              th,
                                          input logic [15:0]              su,
                                          input logic [15:0]              dr,
                                          input logic [15:0]              sy);
    logic [15:0] v;
    logic [4:0]  s;
    v = STS_RESET;
    s = slot_of(a);
    if (a == OFS_DEVICE_STATUS_ONE) begin
      v = d1;
    end else if (a == OFS_THERMAL_STATUS) begin
      v = th;
    end else if (a == OFS_SUPPLY_STATUS) begin
      v = su;
    end else if (a == OFS_DRIVER_STATUS) begin
      v = dr;
    end else if (a == OFS_SYSTEM_STATUS) begin
      v = sy;
    end else if (!s[4]) begin
      v = rg[s[3:0]];
    end
    return v;
  endfunction

  logic sclk_fall;
  logic sclk_rise;
  logic cs_start;
  logic cs_end;

  // link pins are already synchronous, so edges come from one stage
  assign sclk_fall = r_q.sclk & ~SCLK_I;
  assign sclk_rise = ~r_q.sclk & SCLK_I;
  assign cs_start  = r_q.cs_n & ~SCS_N_I;
  assign cs_end    = ~r_q.cs_n & SCS_N_I;

  // serial engine and register writes
  always_comb begin
    logic [15:0] word;
    logic [7:0]  hdr;
    logic [4:0]  s;
    logic [5:0]  nrp;
    word       = {r_q.in_sh[14:0], SDI_I};
    hdr        = word[7:0];
    s          = slot_of(r_q.wptr);
    nrp        = r_q.rptr + 6'h01;
    r_d        = r_q;
    r_d.sclk   = SCLK_I;
    r_d.cs_n   = SCS_N_I;
    r_d.par_ev = 1'b0;
    r_d.frm_ev = 1'b0;
    r_d.clr    = 1'b0;
    r_d.fault_n = ~ds1[DS1_FAULT];
    case (r_q.state)
      SPI_IDLE: begin
        if (cs_start) begin
          // status byte answers the header
          r_d.state  = SPI_HEADER;
          r_d.cnt    = 4'h0;
          r_d.oe_n   = 1'b0;
          r_d.sdo    = ds1[7];
          r_d.out_sh = {ds1[6:0], 9'h000};
          r_d.blk    = 1'b0;
        end
      end
      SPI_HEADER: begin
        if (cs_end) begin
          r_d.state  = SPI_IDLE;
          r_d.oe_n   = 1'b1;
          r_d.frm_ev = 1'b1;                              // short header
        end else if (sclk_rise && r_q.cnt != 4'h0) begin
          r_d.sdo    = r_q.out_sh[15];
          r_d.out_sh = {r_q.out_sh[14:0], 1'b0};
        end else if (sclk_fall) begin
          r_d.in_sh = word;
          r_d.cnt   = r_q.cnt + 4'h1;
          if (r_q.cnt == HDR_LAST) begin
            r_d.state = SPI_DATA;
            r_d.cnt   = 4'h0;
            r_d.rd    = hdr[BIT_HDR_READ];
            if (pen && ^hdr) begin
              // bad header still answers data but never writes
              r_d.par_ev = 1'b1;
              r_d.blk    = 1'b1;
            end else if (!hdr[BIT_HDR_READ]) begin
              r_d.wptr = hdr[6:1];
            end
            if (hdr[BIT_HDR_READ]) begin
              r_d.rptr   = hdr[6:1];
              r_d.out_sh = with_parity(read_of(hdr[6:1], r_q.regs, ds1,
                           therm_sts, supply_status, driver_status, system_status), pen);
            end else begin
              r_d.out_sh = with_parity(read_of(r_q.rptr, r_q.regs, ds1,
                           therm_sts, supply_status, driver_status, system_status), pen);
            end
          end
        end
      end
      SPI_DATA: begin
        if (cs_end) begin
          r_d.state  = SPI_IDLE;
          r_d.oe_n   = 1'b1;
          r_d.frm_ev = (r_q.cnt != 4'h0);                 // partial word
        end else if (sclk_rise) begin
          r_d.sdo    = r_q.out_sh[15];
          r_d.out_sh = {r_q.out_sh[14:0], 1'b0};
        end else if (sclk_fall) begin
          r_d.in_sh = word;
          r_d.cnt   = r_q.cnt + 4'h1;
          if (r_q.cnt == WORD_LAST) begin
            r_d.cnt  = 4'h0;
            r_d.rptr = nrp;
            r_d.out_sh = with_parity(read_of(nrp, r_q.regs, ds1,
                         therm_sts, supply_status, driver_status, system_status), pen);
            if (!r_q.rd) begin
              r_d.wptr = r_q.wptr + 6'h01;
              if (pen && ^word) begin
                // later words of this frame are dropped too
                r_d.par_ev = 1'b1;
                r_d.blk    = 1'b1;
              end else if (!r_q.blk) begin
                if (r_q.wptr == OFS_FAULT_CLEAR) begin
                  r_d.clr = word[BIT_CLEAR_ALL];
                end else if (!s[4]) begin
                  // status offsets have no slot, so writes fall away
                  r_d.regs[s[3:0]] = pen ? {1'b0, word[14:0]} : word;
                end
              end
            end
          end
        end
      end
      default: begin
        r_d.state = SPI_IDLE;
        r_d.oe_n  = 1'b1;
      end
    endcase
  end

  // holes in the map simply have no slot, software keeps off them

  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      r_q.state   <= SPI_IDLE;
      r_q.sclk    <= 1'b0;
      r_q.cs_n    <= 1'b1;
      r_q.cnt     <= 4'h0;
      r_q.in_sh   <= 16'h0000;
      r_q.out_sh  <= 16'h0000;
      r_q.sdo     <= 1'b0;
      r_q.oe_n    <= 1'b1;
      r_q.rd      <= 1'b0;
      r_q.blk     <= 1'b0;
      r_q.rptr    <= 6'h00;
      r_q.wptr    <= 6'h00;
      r_q.regs    <= {NUM_RW{RW_RESET}};
      r_q.par_ev  <= 1'b0;
      r_q.frm_ev  <= 1'b0;
      r_q.clr     <= 1'b0;
      r_q.fault_n <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // level inputs set flags each cycle; link errors arrive as pulses
  always_comb begin
    ev_set             = '0;
    ev_set[EV_OT_WARN] = OT_WARN_I;
    ev_set[EV_OT_SHDN] = OT_SHDN_I;
    ev_set[EV_CP_UV]   = CP_UV_I;
    ev_set[EV_ANALOG_SUPPLY_UV] = ANALOG_SUPPLY_UV_I;
    ev_set[EV_VIN_UV]  = VIN_UV_I;
    ev_set[EV_OCP]     = OCP_I;
    ev_set[EV_OTP]     = OTP_FAULT_I;
    ev_set[EV_PARITY]  = r_q.par_ev;
    ev_set[EV_FRAME]   = r_q.frm_ev;
    ev_clr             = {EV_W{r_q.clr}};
  end

  // power-on flag comes out of reset set
  mds_sticky #(
    .W   (EV_W),
    .RST (EV_RESET)
  ) u_flags (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESET_N_I),
    .set_i   (ev_set),
    .clr_i   (ev_clr),
    .flag_o  (ev)
  );

  assign SDO_O           = r_q.sdo;
  assign SDO_OE_N_O      = r_q.oe_n;
  assign FAULT_N_O       = r_q.fault_n;
  assign PARITY_ENABLE_O = r_q.regs[IDX_SYSCTL][BIT_PARITY_ENABLE];

endmodule
`default_nettype wire

// ===== mds_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mds_host_model (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_n_i,
  output logic      sclk_o,
  output logic      scs_n_o,
  output logic      sdi_o
);
  logic line_q;
  logic idle_q;
  logic act;
  logic sdi_v;
  logic sdo_line;

  // released sdo has no pull, so show the inverse of the last level
  assign sdo_line = sdo_oe_n_i ? ~line_q : sdo_i;
  // sdi wanders outside frames; the device must ignore it there
  assign sdi_o = act ? sdi_v : idle_q;

  initial begin
    line_q = 1'b0;
    idle_q = 1'b0;
    act = 1'b0;
    sdi_v = 1'b0;
    sclk_o = 1'b0;
    scs_n_o = 1'b1;
  end

  // keep the last driven level so a released line shows its inverse
  always @(posedge clk_i) begin
    line_q <= sdo_oe_n_i ? line_q : sdo_i;
    idle_q <= ~idle_q;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // header then nbits data bits, msb first; three cycles per sclk phase
  task automatic xfer(input logic [7:0] hdr, input logic [47:0] dat, input int nbits,
                      output logic [7:0] st, output logic [47:0] rx);
    logic [55:0] sh;
    int          i;
    st = 8'h00;
    rx = 48'h0;
    sh = {hdr, dat << (48 - nbits)};
    tick(1);
    scs_n_o = 1'b0;
    act = 1'b1;
    tick(3);
    for (i = 0; i < 8 + nbits; i++) begin
      sdi_v = sh[55];
      sh = sh << 1;
      sclk_o = 1'b1;
      tick(3);
      if (i < 8) begin
        st = {st[6:0], sdo_line};
      end else begin
        rx = {rx[46:0], sdo_line};
      end
      sclk_o = 1'b0;
      tick(3);
    end
    scs_n_o = 1'b1;
    act = 1'b0;
    tick(3);
  endtask
endmodule
`default_nettype wire

// ===== mds_regmap_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mds_regmap_checker (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic SCLK_I,
  input wire logic SCS_N_I,
  input wire logic SDI_I,
  input wire logic SDO_O,
  input wire logic SDO_OE_N_O,
  input wire logic OT_WARN_I,
  input wire logic OT_SHDN_I,
  input wire logic CP_UV_I,
  input wire logic ANALOG_SUPPLY_UV_I,
  input wire logic VIN_UV_I,
  input wire logic OCP_I,
  input wire logic OTP_FAULT_I,
  input wire logic FAULT_N_O,
  input wire logic PARITY_ENABLE_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  logic any_ev;

  // every input event that counts as a fault for the summary flag; link errors are not included
  assign any_ev = OT_WARN_I | OT_SHDN_I | CP_UV_I | ANALOG_SUPPLY_UV_I | VIN_UV_I | OCP_I | OTP_FAULT_I;

  sequence frame_open;
    SCS_N_I ##1 !SCS_N_I;
  endsequence
  sequence frame_shut;
    SCS_N_I [*2];
  endsequence

  a_reset_vals: assert property (disable iff (1'b0)
    !RESET_N_I |=> SDO_OE_N_O && FAULT_N_O && !PARITY_ENABLE_O)
    else $error("outputs not at reset values");
  a_frame_drive: assert property (frame_open |=> !SDO_OE_N_O)
    else $error("sdo not driven after frame start");
  a_idle_release: assert property (frame_shut |-> SDO_OE_N_O)
    else $error("sdo driven outside frame");
  a_sdo_timing: assert property (
    !SDO_OE_N_O && !$past(SDO_OE_N_O) && $changed(SDO_O) |-> $past(SCLK_I) && !$past(SCLK_I, 2))
    else $error("sdo changed without sclk rise");
  a_pen_change: assert property (
    $changed(PARITY_ENABLE_O) && $past(RESET_N_I) |-> !$past(SCS_N_I) || !$past(SCS_N_I, 2))
    else $error("parity enable changed outside a frame");
  a_fault_raise: assert property (any_ev |-> ##[1:3] !FAULT_N_O)
    else $error("fault pin not asserted after event");
  a_fault_hold: assert property ((SCS_N_I [*3]) ##0 !FAULT_N_O |=> !FAULT_N_O)
    else $error("fault pin released without clear");
  a_por_quiet: assert property (disable iff (1'b0)
    !RESET_N_I ##1 (RESET_N_I && SCS_N_I && !any_ev) [*3] |-> FAULT_N_O)
    else $error("power-on flag drove fault pin");
  a_frame_hold: assert property (!SCS_N_I && !$past(SCS_N_I) |-> !SDO_OE_N_O)
    else $error("sdo released inside frame");
endmodule
bind mds_regmap mds_regmap_checker u_chk (
  .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .SCLK_I(SCLK_I), .SCS_N_I(SCS_N_I),
  .SDI_I(SDI_I), .SDO_O(SDO_O), .SDO_OE_N_O(SDO_OE_N_O), .OT_WARN_I(OT_WARN_I),
  .OT_SHDN_I(OT_SHDN_I), .CP_UV_I(CP_UV_I), .ANALOG_SUPPLY_UV_I(ANALOG_SUPPLY_UV_I), .VIN_UV_I(VIN_UV_I),
  .OCP_I(OCP_I), .OTP_FAULT_I(OTP_FAULT_I), .FAULT_N_O(FAULT_N_O),
  .PARITY_ENABLE_O(PARITY_ENABLE_O));
`default_nettype wire

// ===== mds_regmap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mds_regmap_tb_top;
  import mds_pkg::*;
  logic        ref_clk;
  logic        reset_n;
  logic        sclk;
  logic        scs_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe_n;
  logic        fault_n;
  logic        pen;
  logic [6:0]  ev;
  logic [7:0]  st;
  logic [47:0] rx;
  int          errors;
  int          check_count;

  mds_regmap DUT (.REF_CLK_I(ref_clk), .RESET_N_I(reset_n), .SCLK_I(sclk), .SCS_N_I(scs_n),
    .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n), .OT_WARN_I(ev[0]), .OT_SHDN_I(ev[1]),
    .CP_UV_I(ev[2]), .ANALOG_SUPPLY_UV_I(ev[3]), .VIN_UV_I(ev[4]), .OCP_I(ev[5]), .OTP_FAULT_I(ev[6]),
    .FAULT_N_O(fault_n), .PARITY_ENABLE_O(pen));
  mds_host_model host (.clk_i(ref_clk), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n), .sclk_o(sclk),
    .scs_n_o(scs_n), .sdi_o(sdi));

  // 25 mhz reference
  always #20 ref_clk = ~ref_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [7:0] hdr(input logic r, input logic [5:0] a);
    return {r, a, ^{r, a}};
  endfunction
  function automatic logic [15:0] par(input logic [15:0] v);
    return {^v[14:0], v[14:0]};
  endfunction
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host.xfer(hdr(1'b0, a), {32'h0, d}, 16, st, rx);
  endtask
  task automatic rdchk(input string what, input logic [5:0] a, input logic [15:0] exp);
    host.xfer(hdr(1'b1, a), 48'h0, 16, st, rx);
    chk_word(what, exp, rx[15:0]);
  endtask
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    tick(1);
    ev = 7'h00;
  endtask

  task automatic t_reset_state();
    rdchk("device_status_one", OFS_DEVICE_STATUS_ONE, 16'h0080);
    chk_word("status byte", 16'h0080, {8'h00, st});
    chk_bit("fault pin", 1'b1, fault_n);
    chk_bit("parity enable", 1'b0, pen);
  endtask

  // write every writable offset, then read all back to catch aliasing
  task automatic t_map();
    logic [5:0] ofs [16];
    int         i;
    ofs = '{6'h0c, 6'h10, 6'h12, 6'h13, 6'h16, 6'h17, 6'h18, 6'h19,
            6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h20, 6'h22, 6'h23, 6'h3f};
    for (i = 0; i < 16; i++) wr(ofs[i], {2'b01, ofs[i], 8'h3c});
    for (i = 0; i < 16; i++) begin
      rdchk("rw readback", ofs[i], (ofs[i] == 6'h17) ? 16'h0 : {2'b01, ofs[i], 8'h3c});
    end
    wr(OFS_DEVICE_STATUS_ONE, 16'hffff);
    wr(OFS_THERMAL_STATUS, 16'hffff);
    rdchk("status after write", OFS_DEVICE_STATUS_ONE, 16'h0080);
    rdchk("thermal after write", OFS_THERMAL_STATUS, 16'h0000);
    rdchk("unmapped 01h", 6'h01, 16'h0000);
    rdchk("unmapped 3eh", 6'h3e, 16'h0000);
    host.xfer(hdr(1'b0, OFS_PHASE_A_DUTY), 48'h11112222, 32, st, rx);
    host.xfer(hdr(1'b1, OFS_PHASE_A_DUTY), 48'h0, 32, st, rx);
    chk_word("phase a duty", 16'h1111, rx[31:16]);
    chk_word("phase b duty", 16'h2222, rx[15:0]);
  endtask

  task automatic t_events();
    logic [15:0] ds [7];
    logic [5:0]  so [7];
    logic [15:0] sv [7];
    int          i;
    ds = '{16'h0003, 16'h0003, 16'h0005, 16'h0005, 16'h0005, 16'h0021, 16'h0101};
    so = '{6'h04, 6'h04, 6'h05, 6'h05, 6'h05, 6'h06, 6'h00};
    sv = '{16'h0001, 16'h0002, 16'h0001, 16'h0002, 16'h0004, 16'h0001, 16'h0101};
    wr(OFS_FAULT_CLEAR, 16'h0001);
    rdchk("cleared status", OFS_DEVICE_STATUS_ONE, 16'h0000);
    for (i = 0; i < 7; i++) begin
      pulse(i);
      tick(4);
      chk_bit("fault pin", 1'b0, fault_n);
      rdchk("device_status_one", OFS_DEVICE_STATUS_ONE, ds[i]);
      rdchk("detail status", so[i], sv[i]);
      wr(OFS_FAULT_CLEAR, 16'h0001);
      chk_bit("fault pin cleared", 1'b1, fault_n);
    end
  endtask

  // parity on: read-back parity, then a bad word must be refused
  task automatic t_parity();
    wr(OFS_SYSTEM_CONTROL, 16'h0001);
    chk_bit("parity enable", 1'b1, pen);
    pulse(2);
    pulse(0);
    rdchk("status with parity", OFS_DEVICE_STATUS_ONE, par(16'h0007));
    wr(OFS_SYNC_PERIOD, 16'h0001);
    rdchk("sync kept", OFS_SYNC_PERIOD, par(16'h4c3c));
    rdchk("system_status", OFS_SYSTEM_STATUS, par(16'h0001));
    rdchk("comm fault", OFS_DEVICE_STATUS_ONE, par(16'h0047));
    chk_bit("fault pin", 1'b0, fault_n);
    wr(OFS_SYSTEM_CONTROL, 16'h0000);
    chk_bit("parity disabled", 1'b0, pen);
    wr(OFS_FAULT_CLEAR, 16'h0001);
  endtask

  // chip select lifted in mid-word
  task automatic t_frame_err();
    host.xfer(hdr(1'b0, OFS_SYNC_PERIOD), 48'h00ab, 8, st, rx);
    rdchk("frame error", OFS_SYSTEM_STATUS, 16'h0002);
    rdchk("comm fault", OFS_DEVICE_STATUS_ONE, 16'h0041);
    rdchk("sync kept", OFS_SYNC_PERIOD, 16'h4c3c);
    chk_bit("fault pin", 1'b0, fault_n);
  endtask

  task automatic t_second_reset();
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    // three quiet cycles so the power-on quiet check has something to see
    tick(3);
    rdchk("status after reset", OFS_DEVICE_STATUS_ONE, 16'h0080);
    rdchk("sync after reset", OFS_SYNC_PERIOD, 16'h0000);
    chk_bit("parity enable", 1'b0, pen);
    chk_bit("fault pin", 1'b1, fault_n);
  endtask

  task automatic end_of_test();
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end

  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    ev = 7'h00;
    errors = 0;
    check_count = 0;
    tick(2);
    reset_n = 1'b1;
    tick(3);
    t_reset_state();
    t_map();
    t_events();
    t_parity();
    t_frame_err();
    t_second_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
